// file: verilog/sgc_defines.svh
// Offsets, field positions, masks and reset values for the socket global control slice
`ifndef SGC_DEFINES_SVH
`define SGC_DEFINES_SVH

`define SGC_ADDR_W        12
`define SGC_OFF_STC       12'h804
`define SGC_OFF_GCTL      12'h81e
`define SGC_OFF_IOW0_LO   12'h836
`define SGC_OFF_IOW0_HI   12'h837
`define SGC_OFF_IOW1_LO   12'h838
`define SGC_OFF_IOW1_HI   12'h839
`define SGC_IOW_REGS      4
`define SGC_GCTL_MODEB    4
`define SGC_GCTL_MODEA    3
`define SGC_GCTL_CLRM     2
`define SGC_GCTL_CSCM     1
`define SGC_GCTL_PWRD     0
`define SGC_GCTL_W        5
`define SGC_IOLO_WMASK    8'hfe
`define SGC_IOHI_WMASK    8'hff
`define SGC_STC_W         4
`define SGC_STC_CD_BIT    3
`define SGC_RST_BYTE      8'h00
`define SGC_RST_GCTL      5'h00
`define SGC_RST_STC       4'h0
`define SGC_IRQ_CH        3

`endif

// file: verilog/sgc_pkg.sv
// Types shared by the socket global control slice
package sgc_pkg;
  `include "sgc_defines.svh"

  // One byte access from the socket register space
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`SGC_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
  } sgc_bus_t;

  // Writable part of the global control register, bit 4 down to bit 0
  typedef struct packed {
    logic card_b_irq_signal_select;
    logic card_a_irq_signal_select;
    logic flag_clear_method_select;
    logic status_change_irq_signal_select;
    logic low_power_output_float;
  } sgc_gctl_t;
endpackage

// file: verilog/sgc_irq_sig.sv
// Host interrupt signaller for one source: event pulse or held level
`timescale 1ns/1ps
module sgc_irq_sig (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_mode_i,
  input  wire logic src_level_i,
  input  wire logic src_event_i,
  output logic      irq_o
);
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    irq_nxt = level_mode_i ? src_level_i : src_event_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign irq_o = irq_r;
endmodule // sgc_irq_sig

// file: verilog/sgc_regs.sv
// Socket global control register, I/O window offset bytes and status change flags
`timescale 1ns/1ps
`include "sgc_defines.svh"
module sgc_regs (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             bus_rst_n_i,
  input  wire sgc_pkg::sgc_bus_t bus_i,
  input  wire logic [3:0]       stc_event_i,
  input  wire logic             card_a_irq_i,
  input  wire logic             card_b_irq_i,
  input  wire logic             card_cycle_i,
  output logic [7:0]            rd_data_o,
  output logic                  rd_valid_o,
  output logic                  card_out_en_o,
  output logic                  card_a_host_irq_o,
  output logic                  card_b_host_irq_o,
  output logic                  stc_host_irq_o,
  output logic                  sw_cd_clear_o,
  output logic [15:0]           iow0_offset_o,
  output logic [15:0]           iow1_offset_o
);
  // ****************************************
  // State
  // ****************************************
  sgc_pkg::sgc_gctl_t gctl_r;
  sgc_pkg::sgc_gctl_t gctl_nxt;
  logic [7:0]         iow_r   [`SGC_IOW_REGS];
  logic [7:0]         iow_nxt [`SGC_IOW_REGS];
  logic [3:0]         stc_r;
  logic [3:0]         stc_nxt;
  logic [7:0]         rd_data_r;
  logic [7:0]         rd_data_nxt;
  logic               rd_valid_r;
  logic               rd_valid_nxt;
  logic               out_en_r;
  logic               out_en_nxt;
  logic               sw_cd_r;
  logic               sw_cd_nxt;
  logic               irq_a_prev_r;
  logic               irq_b_prev_r;
  logic [2:0]         mode_v;
  logic [2:0]         lvl_v;
  logic [2:0]         evt_v;
  logic [2:0]         irq_v;
  logic [3:0]         stc_new;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    gctl_nxt     = gctl_r;
    stc_nxt      = stc_r;
    rd_data_nxt  = `SGC_RST_BYTE;
    rd_valid_nxt = bus_i.rd;
    sw_cd_nxt    = 1'b0;
    for (int i = 0; i < `SGC_IOW_REGS; i++) begin
      iow_nxt[i] = iow_r[i];
    end
    // Read path
    if (bus_i.rd) begin
      case (bus_i.addr)
        `SGC_OFF_GCTL:    rd_data_nxt = {3'h0, gctl_r};
        `SGC_OFF_STC:     rd_data_nxt = {4'h0, stc_r};
        `SGC_OFF_IOW0_LO: rd_data_nxt = iow_r[0] & `SGC_IOLO_WMASK;
        `SGC_OFF_IOW0_HI: rd_data_nxt = iow_r[1];
        `SGC_OFF_IOW1_LO: rd_data_nxt = iow_r[2] & `SGC_IOLO_WMASK;
        `SGC_OFF_IOW1_HI: rd_data_nxt = iow_r[3];
        default:          rd_data_nxt = `SGC_RST_BYTE;
      endcase
      // Read-to-clear of the status change flags
      if (bus_i.addr == `SGC_OFF_STC && !gctl_r.flag_clear_method_select) begin
        stc_nxt = `SGC_RST_STC;
      end
    end
    // Write path
    if (bus_i.wr) begin
      case (bus_i.addr)
        `SGC_OFF_GCTL: gctl_nxt = bus_i.wdata[`SGC_GCTL_W-1:0];
        `SGC_OFF_STC: begin
          if (gctl_r.flag_clear_method_select) begin
            stc_nxt   = stc_nxt & ~bus_i.wdata[3:0];
            sw_cd_nxt = bus_i.wdata[`SGC_STC_CD_BIT];
          end
        end
        `SGC_OFF_IOW0_LO: iow_nxt[0] = bus_i.wdata & `SGC_IOLO_WMASK;
        `SGC_OFF_IOW0_HI: iow_nxt[1] = bus_i.wdata & `SGC_IOHI_WMASK;
        `SGC_OFF_IOW1_LO: iow_nxt[2] = bus_i.wdata & `SGC_IOLO_WMASK;
        `SGC_OFF_IOW1_HI: iow_nxt[3] = bus_i.wdata & `SGC_IOHI_WMASK;
        default: ;
      endcase
    end
    // New events win over a read or write clear in the same cycle, but not over a bus reset
    stc_nxt = stc_nxt | stc_event_i;
    // Bus reset spares the clear method, status signalling and power-down bits
    if (!bus_rst_n_i) begin
      gctl_nxt.card_b_irq_signal_select = 1'b0;
      gctl_nxt.card_a_irq_signal_select = 1'b0;
      stc_nxt                           = `SGC_RST_STC;
      sw_cd_nxt                         = 1'b0;
      for (int i = 0; i < `SGC_IOW_REGS; i++) begin
        iow_nxt[i] = `SGC_RST_BYTE;
      end
    end
    // Outputs float between card cycles in power-down
    out_en_nxt = !gctl_r.low_power_output_float || card_cycle_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gctl_r       <= `SGC_RST_GCTL;
      stc_r        <= `SGC_RST_STC;
      rd_data_r    <= `SGC_RST_BYTE;
      rd_valid_r   <= 1'b0;
      out_en_r     <= 1'b0;
      sw_cd_r      <= 1'b0;
      irq_a_prev_r <= 1'b0;
      irq_b_prev_r <= 1'b0;
      for (int i = 0; i < `SGC_IOW_REGS; i++) begin
        iow_r[i] <= `SGC_RST_BYTE;
      end
    end else begin
      gctl_r       <= gctl_nxt;
      stc_r        <= stc_nxt;
      rd_data_r    <= rd_data_nxt;
      rd_valid_r   <= rd_valid_nxt;
      out_en_r     <= out_en_nxt;
      sw_cd_r      <= sw_cd_nxt;
      irq_a_prev_r <= card_a_irq_i;
      irq_b_prev_r <= card_b_irq_i;
      for (int i = 0; i < `SGC_IOW_REGS; i++) begin
        iow_r[i] <= iow_nxt[i];
      end
    end
  end

  // ****************************************
  // Host interrupt signalling
  // ****************************************
  // A flag already set hides a repeat of its event, so edge mode pulses only on fresh flags
  assign stc_new = stc_event_i & ~stc_r;
  assign mode_v  = {gctl_r.status_change_irq_signal_select,
                    gctl_r.card_b_irq_signal_select,
                    gctl_r.card_a_irq_signal_select};
  assign lvl_v   = {|stc_r, card_b_irq_i, card_a_irq_i};
  assign evt_v   = {|stc_new,
                    card_b_irq_i & ~irq_b_prev_r,
                    card_a_irq_i & ~irq_a_prev_r};

  for (genvar g = 0; g < `SGC_IRQ_CH; g++) begin : g_irq
    sgc_irq_sig u_sig (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .level_mode_i (mode_v[g]),
      .src_level_i  (lvl_v[g]),
      .src_event_i  (evt_v[g]),
      .irq_o        (irq_v[g])
    );
  end

  assign card_a_host_irq_o = irq_v[0];
  assign card_b_host_irq_o = irq_v[1];
  assign stc_host_irq_o    = irq_v[2];
  assign rd_data_o         = rd_data_r;
  assign rd_valid_o        = rd_valid_r;
  assign card_out_en_o     = out_en_r;
  assign sw_cd_clear_o     = sw_cd_r;
  assign iow0_offset_o     = {iow_r[1], iow_r[0]};
  assign iow1_offset_o     = {iow_r[3], iow_r[2]};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  gctl_zero_a: assert property (
    bus_i.rd && bus_i.addr == `SGC_OFF_GCTL |=> rd_valid_o && rd_data_o[7:5] == 3'h0)
    else $error("global control reserved bits not zero");

  gctl_back_a: assert property (
    bus_i.wr && bus_i.addr == `SGC_OFF_GCTL && bus_rst_n_i ##1 bus_i.rd &&
    bus_i.addr == `SGC_OFF_GCTL && !bus_i.wr |=> rd_data_o == {3'h0, $past(bus_i.wdata[4:0], 2)})
    else $error("global control read back mismatch");

  edge_b_pulse_a: assert property (
    !gctl_r.card_b_irq_signal_select && $stable(gctl_r) && card_b_host_irq_o
    |=> !card_b_host_irq_o)
    else $error("card B edge interrupt longer than one cycle");

  level_a_hold_a: assert property (
    gctl_r.card_a_irq_signal_select && card_a_irq_i |=> card_a_host_irq_o)
    else $error("card A level interrupt not held");

  read_clear_a: assert property (
    bus_i.rd && bus_i.addr == `SGC_OFF_STC && !gctl_r.flag_clear_method_select &&
    stc_event_i == 4'h0 |=> stc_r == 4'h0)
    else $error("status flags not cleared by read");

  read_keep_a: assert property (
    bus_i.rd && !bus_i.wr && bus_i.addr == `SGC_OFF_STC && bus_rst_n_i &&
    gctl_r.flag_clear_method_select |=> stc_r == ($past(stc_r) | $past(stc_event_i)))
    else $error("status flags cleared by read in write-back mode");

  stc_level_a: assert property (
    gctl_r.status_change_irq_signal_select && stc_r != 4'h0 |=> stc_host_irq_o)
    else $error("status change level interrupt not held");

  float_out_a: assert property (
    gctl_r.low_power_output_float && !card_cycle_i |=> !card_out_en_o)
    else $error("card outputs driven outside a card cycle");

  wake_out_a: assert property (
    card_cycle_i |=> card_out_en_o)
    else $error("card access did not drive outputs");

  bus_rst_keep_a: assert property (
    !bus_rst_n_i && !bus_i.wr |=> gctl_r[2:0] == $past(gctl_r[2:0]) &&
    gctl_r[4:3] == 2'h0)
    else $error("bus reset touched global-reset-only bits");

  lo_bit0_a: assert property (
    1'b1 |-> iow0_offset_o[0] == 1'b0 && iow1_offset_o[0] == 1'b0)
    else $error("window offset bit 0 not zero");

  hi_write_a: assert property (
    bus_i.wr && bus_i.addr == `SGC_OFF_IOW1_HI && bus_rst_n_i
    |=> iow1_offset_o[15:8] == $past(bus_i.wdata))
    else $error("window 1 high byte write lost");

  cd_clear_a: assert property (
    bus_i.wr && bus_i.addr == `SGC_OFF_STC && gctl_r.flag_clear_method_select &&
    bus_i.wdata[3] && bus_rst_n_i |=> sw_cd_clear_o)
    else $error("software card detect clear missing");

  edge_stc_a: assert property (
    !gctl_r.status_change_irq_signal_select && $stable(gctl_r) &&
    (stc_event_i & ~stc_r) != 4'h0 |=> stc_host_irq_o)
    else $error("status change edge pulse missing");
endmodule // sgc_regs

// file: test/sgc_card_model.sv
// Behavioural card that raises interrupt levels and runs card cycles on request
`timescale 1ns/1ps
module sgc_card_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] req_i,
  output logic      [2:0] card_o
);
  // A real card answers a clock late; bit 0 card A, bit 1 card B, bit 2 active cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_o <= 3'h0;
    end else begin
      card_o <= req_i;
    end
  end
endmodule // sgc_card_model

// file: test/tb_socket_global_ctrl_io_offset.sv
// Self-checking bench for the socket global control and window offset slice
`timescale 1ns/1ps
module tb_socket_global_ctrl_io_offset;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              bus_rst_n = 1'b1;
  sgc_pkg::sgc_bus_t bus = '0;
  logic [3:0]        stc_ev = 4'h0;
  logic [2:0]        req = 3'h0;
  logic [2:0]        card;
  logic [7:0]        rd_data, lo, hi;
  logic [15:0]       iow0, iow1;
  logic [11:0]       a;
  logic              rd_valid, out_en, irq_a, irq_b, irq_c, cd_clr, w;
  integer            n_fail = 0;
  integer            n_tests = 0;
  integer            seed = 76;

  always #25 clk = ~clk;

  sgc_card_model i_card (.core_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .card_o(card));

  sgc_regs i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .bus_rst_n_i(bus_rst_n), .bus_i(bus),
    .stc_event_i(stc_ev), .card_a_irq_i(card[0]), .card_b_irq_i(card[1]),
    .card_cycle_i(card[2]), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .card_out_en_o(out_en), .card_a_host_irq_o(irq_a), .card_b_host_irq_o(irq_b),
    .stc_host_irq_o(irq_c), .sw_cd_clear_o(cd_clr), .iow0_offset_o(iow0),
    .iow1_offset_o(iow1)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] exp_lo(input logic [7:0] d);
    return d & 8'hfe;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Idle cycle after each write so the strobe is never reassigned in one step
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, ad, d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [7:0] e);
    bus <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk("rd_valid", 1'h1, rd_valid);
    chk("rd_data", e, rd_data);
    @(posedge clk);
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    edges(1);
    chk("out_en", 1'h1, out_en);
    @(posedge clk);
    rd(12'h81e, 8'h00);
    for (int i = 0; i < 4; i++) rd(12'h836 + 12'(i), 8'h00);
    rd(12'h900, 8'h00);
    for (int i = 0; i < 12; i++) begin
      w = i[0];
      lo = (i == 0) ? 8'hff : 8'($random(seed));
      hi = 8'($random(seed));
      a = 12'h836 + {10'h000, w, 1'b0};
      wr(a, lo);
      wr(a + 12'h001, hi);
      rd(a, exp_lo(lo));
      rd(a + 12'h001, hi);
      chk("iow_offset", {hi, exp_lo(lo)}, w ? iow1 : iow0);
    end
    wr(12'h81e, 8'hff);
    rd(12'h81e, 8'h1f);
    chk("out_en", 1'h0, out_en);
    req <= 3'h3;
    edges(4);
    chk("irq_a", 1'h1, irq_a);
    chk("irq_b", 1'h1, irq_b);
    chk("out_en", 1'h0, out_en);
    @(posedge clk);
    req <= 3'h4;
    edges(2);
    chk("out_en", 1'h1, out_en);
    chk("irq_a", 1'h0, irq_a);
    @(posedge clk);
    req <= 3'h0;
    edges(2);
    chk("out_en", 1'h0, out_en);
    @(posedge clk);
    bus_rst_n <= 1'b0;
    @(posedge clk);
    bus_rst_n <= 1'b1;
    rd(12'h81e, 8'h07);
    rd(12'h837, 8'h00);
    stc_ev <= 4'h8;
    @(posedge clk);
    stc_ev <= 4'h0;
    edges(2);
    chk("irq_c", 1'h1, irq_c);
    @(posedge clk);
    rd(12'h804, 8'h08);
    rd(12'h804, 8'h08);
    bus <= '{1'b1, 1'b0, 12'h804, 8'h08};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk("cd_clr", 1'h1, cd_clr);
    @(posedge clk);
    rd(12'h804, 8'h00);
    chk("irq_c", 1'h0, irq_c);
    wr(12'h81e, 8'h00);
    stc_ev <= 4'h8;
    @(posedge clk);
    stc_ev <= 4'h0;
    @(negedge clk);
    chk("irq_c", 1'h1, irq_c);
    edges(1);
    chk("irq_c", 1'h0, irq_c);
    chk("out_en", 1'h1, out_en);
    @(posedge clk);
    rd(12'h804, 8'h08);
    rd(12'h804, 8'h00);
    req <= 3'h3;
    edges(2);
    chk("irq_b", 1'h1, irq_b);
    chk("irq_a", 1'h1, irq_a);
    edges(1);
    chk("irq_b", 1'h0, irq_b);
    chk("irq_a", 1'h0, irq_a);
    @(posedge clk);
    req <= 3'h0;
    // Write then read straight after: the read must already see the new value
    bus <= '{1'b1, 1'b0, 12'h81e, 8'h07};
    @(posedge clk);
    bus <= '{1'b0, 1'b1, 12'h81e, 8'h00};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk("rd_data", 8'h07, rd_data);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'h81e, 8'h00);
    wrap_up();
  end
endmodule // tb_socket_global_ctrl_io_offset
